// file: design/bmc_defs.svh
// Purpose: Constants of the burst setting and readout block
// Assumes: Included by its bare name
// Notes: Setting code holds address bits 18 to 12
`ifndef BMC_DEFS_SVH
`define BMC_DEFS_SVH
`define BMC_CLK_NS 20
`define BMC_SLEEP_EXTRA_NS 60
`define BMC_CMD_UNLOCK1 16'h00AA
`define BMC_CMD_UNLOCK2 16'h0055
`define BMC_CMD_CFG 16'h00C0
`define BMC_CMD_READOUT 16'h0090
`define BMC_CMD_RESET 16'h00F0
`define BMC_ADR_UNLOCK1 12'h555
`define BMC_ADR_UNLOCK2 12'h2AA
`define BMC_CFG_LSB 12
`define BMC_CFG_MSB 18
`define BMC_CFG_RESET 7'h03
`define BMC_MODE_MAX 3'h4
`define BMC_WAIT_MAX 3'h3
`define BMC_WAIT_BASE 4'h4
`define BMC_LEN8 5'h08
`define BMC_LEN16 5'h10
`define BMC_OFS_MAKER 2'h0
`define BMC_OFS_DEVICE 2'h1
`define BMC_OFS_PROT 2'h2
`define BMC_PIN_IDLE 27'h3C00000
`endif

// file: design/bmc_pkg.sv
// Purpose: Types of the burst setting and readout block
// Assumes: Used by scoped names only
// Notes: Setting struct follows address bits 18 down to 12
package bmc_pkg;
	typedef enum logic [2:0] {
		MODE_CONT = 3'h0,
		MODE_WRAP8 = 3'h1,
		MODE_WRAP16 = 3'h2,
		MODE_LIN8 = 3'h3,
		MODE_LIN16 = 3'h4
	} bmc_mode_t;

	typedef struct packed {
		logic rdy_early;
		bmc_mode_t mode;
		logic [2:0] wait_code;
	} bmc_cfg_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_BURST = 3'b100
	} bmc_state_t;

	typedef struct packed {
		logic fclk;
		logic address_valid_n;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [5:0] a_hi;
		logic [15:0] adq;
	} bmc_pins_t;
endpackage : bmc_pkg

// file: design/bmc_sync.sv
// Purpose: Two-flop synchroniser for host pins
// Assumes: Each bit changes independently
// Notes: Only the second stage is visible
`timescale 1ns/1ns
`default_nettype none
module bmc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Data
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			meta_r <= RST;
			o_q <= RST;
		end
		else
		begin
			meta_r <= i_d;
			o_q <= meta_r;
		end
	end
endmodule : bmc_sync
`default_nettype wire

// file: design/bmc_fifo.sv
// Purpose: Word FIFO between array reads and burst output
// Assumes: Depth is a power of two
// Notes: Flush empties it in one cycle
`timescale 1ns/1ns
`default_nettype none
module bmc_fifo #(
	parameter int W = 16,
	parameter int D = 16
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_flush,
	// Fill side
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	// Drain side
	output logic o_valid,
	input wire logic i_ready,
	output logic [W-1:0] o_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_r [D];
	logic [AW:0] wr_r;
	logic [AW:0] rd_r;
	wire logic wr_en = i_valid & o_ready;
	wire logic rd_en = o_valid & i_ready;

	assign o_ready = (wr_r - rd_r) != (AW + 1)'(D);
	assign o_valid = wr_r != rd_r;
	assign o_data = mem_r[rd_r[AW-1:0]];

	always_ff @(posedge i_clk)
	begin
		if (wr_en)
			mem_r[wr_r[AW-1:0]] <= i_data;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n || i_flush)
		begin
			wr_r <= '0;
			rd_r <= '0;
		end
		else
		begin
			if (wr_en)
				wr_r <= wr_r + 1'b1;
			if (rd_en)
				rd_r <= rd_r + 1'b1;
		end
	end
endmodule : bmc_fifo
`default_nettype wire

// file: design/bmc_burst_cfg.sv
// Purpose: Burst setting, wait states, ready timing, ID readout
// Assumes: Host pins are asynchronous to i_clk
// Notes: Array words reach the bus through a FIFO
//
// Summary of operation
// RL1 - Power-up initial burst access uses seven cycles
// RL2 - Ready rises with first valid burst word
// RL3 - Third write C0h at 555h loads setting
// RL4 - Host loads setting before dependent bursts
// RL5 - Reset restores every setting field default
// RL6 - Setting bit selects early or aligned ready
// RL7 - Three bits choose continuous, wrap, no-wrap
// RL8 - Wait code picks 4th to 7th edge
// RL9 - Boundary crossing: ready rises with data
// RL10 - Wrap bursts stay inside aligned group
// RL11 - No-wrap bursts advance linearly for length
// RL12 - Clock edge with strobe low starts burst
// RL13 - Readout mode allows asynchronous reads only
// RL14 - Two unlocks then command enter readout
// RL15 - Host avoids readout command while busy
// RL16 - Readout serves any number of reads
// RL17 - Reset command F0h leaves readout mode
// RL18 - Offsets 0,1,2 give maker, device, protection
// RL19 - Standby forces outputs off regardless of enable
// RL20 - Deselect never aborts running program or erase
// RL21 - Stable address enters sleep, data kept
// RL22 - Reserved codes keep previous field value
`timescale 1ns/1ns
`default_nettype none
`include "bmc_defs.svh"
module bmc_burst_cfg #(
	parameter int ARRAY_NS = 100,
	parameter logic [15:0] MAKER_ID = 16'h00A5,
	parameter logic [15:0] DEVICE_ID = 16'h5A01,
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Host pins
	input wire logic i_fclk,
	input wire logic i_address_valid_n,
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic [5:0] i_a_hi,
	input wire logic [15:0] i_adq,
	output logic [15:0] o_adq,
	output logic o_adq_oe,
	output logic o_rdy,
	// Array side
	output logic o_arr_req,
	output logic [21:0] o_arr_addr,
	input wire logic i_arr_valid,
	input wire logic [15:0] i_arr_data,
	input wire logic i_arr_busy,
	input wire logic i_blk_prot,
	// Status
	output logic [6:0] o_cfg,
	output logic o_readout,
	output logic o_sleep,
	output logic o_busy
);
	// ID values above are arbitrary
	localparam int SLEEP_NS = ARRAY_NS + `BMC_SLEEP_EXTRA_NS;
	localparam int SLEEP_CYC = (SLEEP_NS + `BMC_CLK_NS - 1) / `BMC_CLK_NS;

	bmc_pkg::bmc_pins_t pin_raw;
	bmc_pkg::bmc_pins_t p;
	bmc_pkg::bmc_cfg_t cfg_r;
	bmc_pkg::bmc_cfg_t cfg_nxt;
	bmc_pkg::bmc_cfg_t cfg_new;
	bmc_pkg::bmc_state_t state_r;
	bmc_pkg::bmc_state_t state_nxt;
	logic fclk_q;
	logic we_q;
	logic [1:0] seq_r;
	logic readout_r;
	logic [21:0] addr_r;
	logic [21:0] last_r;
	logic [21:0] req_addr_r;
	logic [21:0] step_addr;
	logic [3:0] edge_r;
	logic due_r;
	logic pend_r;
	logic drop_r;
	logic [4:0] left_r;
	logic [4:0] shown_r;
	logic [7:0] sleep_r;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [15:0] fifo_out_data;

	assign pin_raw = {i_fclk, i_address_valid_n, i_ce_n, i_oe_n, i_we_n, i_a_hi, i_adq};

	bmc_sync #(.W(27), .RST(`BMC_PIN_IDLE)) u_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_d(pin_raw),
		.o_q(p)
	);

	// Decode of pins and state
	wire logic sel = ~p.ce_n;
	wire logic fclk_rise = p.fclk & ~fclk_q;
	wire logic we_rise = p.we_n & ~we_q & sel;
	wire logic [21:0] bus_addr = {p.a_hi, p.adq};
	wire logic idle = state_r == bmc_pkg::ST_IDLE;
	wire logic in_burst = state_r == bmc_pkg::ST_BURST;
	wire logic rd_cyc = sel & ~p.oe_n;
	// RL12 strobe-low edge start
	// RL13 no burst in readout
	wire logic start = fclk_rise & ~p.address_valid_n & sel & ~readout_r;
	// RL8 first data edge
	wire logic [3:0] first_edge = `BMC_WAIT_BASE + {1'b0, cfg_r.wait_code};
	wire logic [3:0] edge_nxt = edge_r + 4'h1;
	wire logic wait_edge = (state_r == bmc_pkg::ST_WAIT) & fclk_rise & p.address_valid_n;
	// RL7 mode decode
	wire logic fixed = cfg_r.mode != bmc_pkg::MODE_CONT;
	wire logic len16 = (cfg_r.mode == bmc_pkg::MODE_WRAP16) | (cfg_r.mode == bmc_pkg::MODE_LIN16);
	wire logic [4:0] burst_len = len16 ? `BMC_LEN16 : `BMC_LEN8;
	wire logic want = in_burst & (due_r | fclk_rise) & ((shown_r != 5'h00) | ~fixed);
	wire logic pop = want & fifo_out_valid;
	wire logic more = (left_r != 5'h00) | ~fixed;
	wire logic issue = ~idle & ~start & ~pend_r & fifo_in_ready & more;
	wire logic push = i_arr_valid & pend_r & ~drop_r & ~start;
	// RL14 unlock and command decode
	wire logic unlock1 = (p.adq == `BMC_CMD_UNLOCK1) & (addr_r[11:0] == `BMC_ADR_UNLOCK1);
	wire logic unlock2 = (p.adq == `BMC_CMD_UNLOCK2) & (addr_r[11:0] == `BMC_ADR_UNLOCK2);
	wire logic reset_cmd = we_rise & idle & (p.adq == `BMC_CMD_RESET);
	wire logic third = we_rise & idle & (seq_r == 2'h2);
	// RL3 setting load command
	wire logic cfg_cmd = third & (p.adq == `BMC_CMD_CFG) & (addr_r[11:0] == `BMC_ADR_UNLOCK1);
	// RL15 entry refused while busy
	wire logic ro_cmd = third & (p.adq == `BMC_CMD_READOUT) & ~i_arr_busy;
	// RL18 readout word select
	wire logic [15:0] id_word = (addr_r[1:0] == `BMC_OFS_MAKER) ? MAKER_ID :
		(addr_r[1:0] == `BMC_OFS_DEVICE) ? DEVICE_ID :
		(addr_r[1:0] == `BMC_OFS_PROT) ? {15'h0000, i_blk_prot} : 16'h0000;

	assign cfg_new = bmc_pkg::bmc_cfg_t'(addr_r[`BMC_CFG_MSB:`BMC_CFG_LSB]);
	assign o_cfg = cfg_r;
	assign o_readout = readout_r;

	// RL10 wrap inside group
	// RL11 linear step otherwise
	assign step_addr = (cfg_r.mode == bmc_pkg::MODE_WRAP8) ?
		{req_addr_r[21:3], req_addr_r[2:0] + 3'h1} :
		(cfg_r.mode == bmc_pkg::MODE_WRAP16) ?
		{req_addr_r[21:4], req_addr_r[3:0] + 4'h1} : req_addr_r + 22'h000001;

	// RL22 reserved codes ignored
	always_comb
	begin
		cfg_nxt = cfg_r;
		if (cfg_cmd)
		begin
			cfg_nxt.rdy_early = cfg_new.rdy_early;
			if (cfg_new.mode <= `BMC_MODE_MAX)
				cfg_nxt.mode = cfg_new.mode;
			if (cfg_new.wait_code <= `BMC_WAIT_MAX)
				cfg_nxt.wait_code = cfg_new.wait_code;
		end
	end

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			bmc_pkg::ST_IDLE:
				if (start)
					state_nxt = bmc_pkg::ST_WAIT;
			bmc_pkg::ST_WAIT:
				if (start)
					state_nxt = bmc_pkg::ST_WAIT;
				else if (!sel)
					state_nxt = bmc_pkg::ST_IDLE;
				else if (wait_edge && edge_nxt == first_edge)
					state_nxt = bmc_pkg::ST_BURST;
			bmc_pkg::ST_BURST:
				if (start)
					state_nxt = bmc_pkg::ST_WAIT;
				else if (!sel || (fixed && shown_r == 5'h00 && fclk_rise))
					state_nxt = bmc_pkg::ST_IDLE;
			default:
				state_nxt = bmc_pkg::ST_IDLE;
		endcase
	end

	bmc_fifo #(.W(16), .D(FIFO_DEPTH)) u_fifo (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_flush(start),
		.i_valid(push),
		.o_ready(fifo_in_ready),
		.i_data(i_arr_data),
		.o_valid(fifo_out_valid),
		.i_ready(want),
		.o_data(fifo_out_data)
	);

	// Pin history and latched address
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			fclk_q <= 1'b0;
			we_q <= 1'b1;
			addr_r <= 22'h000000;
		end
		else
		begin
			fclk_q <= p.fclk;
			we_q <= p.we_n;
			if (!p.address_valid_n && sel)
				addr_r <= bus_addr;
		end
	end

	// RL5 defaults on reset
	// RL1 seven-cycle default
	// RL16 readout held until reset command
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			seq_r <= 2'h0;
			readout_r <= 1'b0;
			cfg_r <= `BMC_CFG_RESET;
		end
		else
		begin
			cfg_r <= cfg_nxt;
			// RL17 reset command exit
			if (reset_cmd)
			begin
				seq_r <= 2'h0;
				readout_r <= 1'b0;
			end
			else if (we_rise && idle)
			begin
				case (seq_r)
					2'h0:
						seq_r <= {1'b0, unlock1};
					2'h1:
						seq_r <= unlock2 ? 2'h2 : 2'h0;
					default:
						seq_r <= 2'h0;
				endcase
				if (ro_cmd)
					readout_r <= 1'b1;
			end
		end
	end

	// Burst sequencing and ready
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			state_r <= bmc_pkg::ST_IDLE;
			edge_r <= 4'h0;
			due_r <= 1'b0;
			shown_r <= 5'h00;
			o_rdy <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			if (start)
			begin
				edge_r <= 4'h0;
				due_r <= 1'b0;
				shown_r <= burst_len;
				o_rdy <= 1'b0;
			end
			else if (wait_edge)
			begin
				edge_r <= edge_nxt;
				due_r <= edge_nxt == first_edge;
				// RL6 early ready option
				if (cfg_r.rdy_early && edge_nxt == first_edge - 4'h1)
					o_rdy <= 1'b1;
			end
			// RL2 ready marks first word
			// RL9 ready rises with data
			else if (pop)
			begin
				due_r <= 1'b0;
				o_rdy <= 1'b1;
				if (fixed)
					shown_r <= shown_r - 5'h01;
			end
			else if (want)
			begin
				due_r <= 1'b1;
				o_rdy <= 1'b0;
			end
			if (state_nxt == bmc_pkg::ST_IDLE)
				o_rdy <= 1'b0;
		end
	end

	// Array read requests
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			o_arr_req <= 1'b0;
			o_arr_addr <= 22'h000000;
			req_addr_r <= 22'h000000;
			left_r <= 5'h00;
			pend_r <= 1'b0;
			drop_r <= 1'b0;
		end
		else
		begin
			o_arr_req <= issue;
			if (i_arr_valid)
				drop_r <= 1'b0;
			if (start)
			begin
				req_addr_r <= bus_addr;
				left_r <= burst_len;
				drop_r <= pend_r & ~i_arr_valid;
			end
			else if (issue)
			begin
				o_arr_addr <= req_addr_r;
				req_addr_r <= step_addr;
				if (fixed)
					left_r <= left_r - 5'h01;
			end
			if (issue)
				pend_r <= 1'b1;
			else if (i_arr_valid)
				pend_r <= 1'b0;
		end
	end

	// Bus drive, sleep and busy
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			o_adq <= 16'h0000;
			o_adq_oe <= 1'b0;
			last_r <= 22'h000000;
			sleep_r <= 8'h00;
			o_sleep <= 1'b0;
			o_busy <= 1'b0;
		end
		else
		begin
			// RL19 standby outputs off
			o_adq_oe <= rd_cyc & (readout_r | in_burst);
			if (pop)
				o_adq <= fifo_out_data;
			else if (readout_r && rd_cyc && idle)
				o_adq <= id_word;
			last_r <= bus_addr;
			// RL21 sleep on stable address
			if (bus_addr != last_r)
			begin
				sleep_r <= 8'h00;
				o_sleep <= 1'b0;
			end
			else if (sleep_r == SLEEP_CYC[7:0])
				o_sleep <= 1'b1;
			else
				sleep_r <= sleep_r + 8'h01;
			// RL20 busy ignores deselect
			o_busy <= i_arr_busy;
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	sequence s_last_wait;
		wait_edge && sel && edge_nxt == first_edge;
	endsequence
	sequence s_enter_burst;
		##1 (state_r == bmc_pkg::ST_BURST) && due_r;
	endsequence

	a_first_edge: assert property (s_last_wait |-> s_enter_burst) // RL8
		else $error("burst not entered on chosen edge");
	a_default_seven: assert property (cfg_r.wait_code == 3'h3 |-> first_edge == 4'h7) // RL1
		else $error("default wait is not seven");
	a_cfg_reset: assert property (disable iff (1'b0) !i_reset_n |=> cfg_r == 7'h03) // RL5
		else $error("setting not default after reset");
	a_cfg_load: assert property (cfg_cmd && cfg_new.mode <= 3'h4 && cfg_new.wait_code <= 3'h3
		|=> cfg_r == $past(cfg_new)) // RL3
		else $error("setting not loaded");
	a_rsvd_kept: assert property (cfg_cmd && cfg_new.mode > 3'h4
		|=> cfg_r.mode == $past(cfg_r.mode)) // RL22
		else $error("reserved mode adopted");
	a_rdy_data: assert property (pop && !start && state_nxt != bmc_pkg::ST_IDLE
		|=> o_rdy && o_adq == $past(fifo_out_data)) // RL9
		else $error("ready not with data");
	a_standby_off: assert property (p.ce_n |=> !o_adq_oe) // RL19
		else $error("bus driven in standby");
	a_readout_nob: assert property (readout_r && idle |=> state_r != bmc_pkg::ST_WAIT) // RL13
		else $error("burst started in readout");
	a_wrap_group: assert property (issue && cfg_r.mode == bmc_pkg::MODE_WRAP8
		|=> req_addr_r[21:3] == $past(req_addr_r[21:3])) // RL10
		else $error("wrap left its group");
	a_readout_exit: assert property (reset_cmd |=> !readout_r) // RL17
		else $error("readout not left");
	a_sleep_enter: assert property (sleep_r == SLEEP_CYC[7:0] && bus_addr == last_r
		|=> o_sleep) // RL21
		else $error("sleep not entered");
endmodule : bmc_burst_cfg
`default_nettype wire

// file: testbench/bmc_array_model.sv
// Purpose: Array stand-in answering word reads
// Assumes: One request outstanding at a time
// Notes: Word is address xor 3C3C; data line toggles when idle
`timescale 1ns/1ns
`default_nettype none
module bmc_array_model #(
	parameter int LAT = 2
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Request side
	input wire logic i_req,
	input wire logic [21:0] i_addr,
	// Answer side
	output logic o_valid,
	output logic [15:0] o_data
);
	logic [21:0] addr_r;
	int cnt_r;
	always_ff @(posedge i_clk)
	begin
		o_valid <= 1'b0;
		o_data <= ~o_data;
		if (!i_reset_n)
		begin
			cnt_r <= 0;
			o_data <= 16'h0000;
		end
		else if (i_req)
		begin
			addr_r <= i_addr;
			cnt_r <= LAT;
		end
		else if (cnt_r == 1)
		begin
			o_valid <= 1'b1;
			o_data <= addr_r[15:0] ^ 16'h3C3C;
			cnt_r <= 0;
		end
		else if (cnt_r > 1)
			cnt_r <= cnt_r - 1;
	end
endmodule : bmc_array_model
`default_nettype wire

// file: testbench/test_burst_config_and_id_readout.sv
// Purpose: Self-checking bench of the burst setting block
// Assumes: Host pins driven by tasks, array by a model
// Notes: Burst clock pin toggles every 6 system cycles
`timescale 1ns/1ns
`default_nettype none
module test_burst_config_and_id_readout;
	// Identity values are arbitrary
	localparam logic [15:0] MAKER = 16'h1234;
	localparam logic [15:0] DEVICE = 16'h4321;
	localparam int LIMIT = 20000;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic fclk = 1'b0;
	logic address_valid_n = 1'b1;
	logic ce_n = 1'b1;
	logic oe_n = 1'b1;
	logic we_n = 1'b1;
	logic [5:0] a_hi = 6'h00;
	logic [15:0] adq = 16'h0000;
	logic arr_busy = 1'b0;
	logic blk_prot = 1'b0;
	logic [15:0] adq_out;
	logic adq_oe;
	logic rdy;
	logic arr_req;
	logic [21:0] arr_addr;
	logic arr_valid;
	logic [15:0] arr_data;
	logic [6:0] cfg;
	logic readout;
	logic sleep;
	logic busy;
	logic [6:0] c;
	int miscompares = 0;
	int n_checks = 0;
	int cyc_cnt = 0;

	always #10 clk = ~clk;

	bmc_burst_cfg #(.ARRAY_NS(100), .MAKER_ID(MAKER), .DEVICE_ID(DEVICE), .FIFO_DEPTH(16)) dut_u (
		.i_clk(clk), .i_reset_n(reset_n), .i_fclk(fclk), .i_address_valid_n(address_valid_n),
		.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_a_hi(a_hi), .i_adq(adq),
		.o_adq(adq_out), .o_adq_oe(adq_oe), .o_rdy(rdy), .o_arr_req(arr_req),
		.o_arr_addr(arr_addr), .i_arr_valid(arr_valid), .i_arr_data(arr_data),
		.i_arr_busy(arr_busy), .i_blk_prot(blk_prot), .o_cfg(cfg), .o_readout(readout),
		.o_sleep(sleep), .o_busy(busy)
	);

	bmc_array_model #(.LAT(2)) array_u (
		.i_clk(clk), .i_reset_n(reset_n), .i_req(arr_req), .i_addr(arr_addr),
		.o_valid(arr_valid), .o_data(arr_data)
	);

	task print_verdict;
		$display("Checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	always @(posedge clk)
	begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == LIMIT)
		begin
			miscompares++;
			print_verdict();
		end
	end

	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task chk16(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		if (got !== exp)
			miscompares++;
	endtask : chk16

	task chk7(input logic [6:0] got, input logic [6:0] exp);
		chk16({9'h000, got}, {9'h000, exp});
	endtask : chk7

	task chk1(input logic got, input logic exp);
		chk16({15'h0000, got}, {15'h0000, exp});
	endtask : chk1

	task wr(input logic [21:0] a, input logic [15:0] d);
		@(posedge clk);
		ce_n <= 1'b0;
		address_valid_n <= 1'b0;
		a_hi <= a[21:16];
		adq <= a[15:0];
		cyc(4);
		address_valid_n <= 1'b1;
		adq <= d;
		cyc(4);
		we_n <= 1'b0;
		cyc(4);
		we_n <= 1'b1;
		cyc(4);
		ce_n <= 1'b1;
		adq <= ~d;
		cyc(4);
	endtask : wr

	task unlock;
		wr(22'h000555, 16'h00AA);
		wr(22'h0002AA, 16'h0055);
	endtask : unlock

	task rd(input logic [21:0] a, input logic [15:0] e);
		@(posedge clk);
		ce_n <= 1'b0;
		address_valid_n <= 1'b0;
		a_hi <= a[21:16];
		adq <= a[15:0];
		cyc(4);
		address_valid_n <= 1'b1;
		adq <= ~a[15:0];
		oe_n <= 1'b0;
		cyc(8);
		chk16(adq_out, e);
		chk1(adq_oe, 1'b1);
		oe_n <= 1'b1;
		ce_n <= 1'b1;
		cyc(4);
	endtask : rd

	task tick;
		cyc(6);
		fclk <= 1'b1;
		cyc(6);
		fclk <= 1'b0;
	endtask : tick

	task burst(input logic [21:0] a, input int n, input int fr, input int len, input int grp,
		input bit fixed);
		logic [21:0] e;
		@(posedge clk);
		ce_n <= 1'b0;
		address_valid_n <= 1'b0;
		a_hi <= a[21:16];
		adq <= a[15:0];
		tick();
		address_valid_n <= 1'b1;
		adq <= ~a[15:0];
		oe_n <= 1'b0;
		for (int k = 1; k < n + len; k++)
		begin
			tick();
			chk1(rdy, k >= fr);
			e = (grp == 0) ? a + 22'(k - n) :
				((a & ~22'(grp - 1)) | ((a + 22'(k - n)) & 22'(grp - 1)));
			if (k >= n)
				chk16(adq_out, e[15:0] ^ 16'h3C3C);
		end
		if (fixed)
			tick();
		if (fixed)
			chk1(rdy, 1'b0);
		ce_n <= 1'b1;
		oe_n <= 1'b1;
		cyc(6);
		chk1(rdy, 1'b0);
		chk1(adq_oe, 1'b0);
	endtask : burst

	initial
	begin
		cyc(16);
		reset_n <= 1'b1;
		cyc(2);
		chk7(cfg, 7'h03);
		$display("Test reset done");
		burst(22'h001230, 7, 7, 4, 0, 1'b0);
		$display("Test default burst done");
		unlock();
		wr(22'h075555, 16'h00C0);
		chk7(cfg, 7'h43);
		$display("Test reserved codes done");
		for (int m = 1; m <= 4; m++)
		begin
			c = {m[0], m[2:0], 3'(m - 1)};
			unlock();
			wr({3'h0, c, 12'h555}, 16'h00C0);
			chk7(cfg, c);
			burst(22'h23456A, 3 + m, m[0] ? 2 + m : 3 + m, m[0] ? 8 : 16, m * 8 * (m <= 2),
				1'b1);
		end
		$display("Test burst modes done");
		arr_busy <= 1'b1;
		unlock();
		wr(22'h0F0000, 16'h0090);
		chk1(readout, 1'b0);
		chk1(busy, 1'b1);
		arr_busy <= 1'b0;
		unlock();
		wr(22'h0F0000, 16'h0090);
		chk1(readout, 1'b1);
		rd(22'h0F0000, MAKER);
		rd(22'h0F0001, DEVICE);
		blk_prot <= 1'b1;
		rd(22'h0F8002, 16'h0001);
		blk_prot <= 1'b0;
		rd(22'h0F8002, 16'h0000);
		ce_n <= 1'b0;
		oe_n <= 1'b0;
		cyc(24);
		chk1(sleep, 1'b1);
		chk16(adq_out, 16'h0000);
		ce_n <= 1'b1;
		cyc(6);
		chk1(adq_oe, 1'b0);
		oe_n <= 1'b1;
		adq <= 16'h1111;
		cyc(6);
		chk1(sleep, 1'b0);
		wr(22'h000000, 16'h00F0);
		chk1(readout, 1'b0);
		$display("Test readout done");
		reset_n <= 1'b0;
		cyc(16);
		reset_n <= 1'b1;
		cyc(2);
		chk7(cfg, 7'h03);
		$display("Test hardware reset done");
		print_verdict();
	end
endmodule : test_burst_config_and_id_readout
`default_nettype wire
